// *** core_vendor_regs.svh ***
`ifndef CORE_VENDOR_REGS_SVH
`define CORE_VENDOR_REGS_SVH
`define OPC_MAIN 3'h0
`define OPC_WFI 3'h2
`define SEL_SIZE 4'h0
`define SEL_CFG 4'h1
`define SEL_HIGH 4'h2
`define SEL_LOW 4'h3
`define SEL_THREAD 4'h4
`define SEL_STATUS 4'h8
`define CFG_STREAM_BIT 7
`define CFG_RSVD_BIT 6
`define CFG_OS_BIT 5
`define CFG_CLEAN_BIT 2
`define CFG_TRANSP_BIT 1
`define CFG_LOCK_BIT 0
`define CFG_WR_MASK 32'h000000A7
`define CFG_RESET 32'h00000001
`define STAT_DIRTY_BIT 31
`define STAT_ABORT_BIT 4
`define IDX_LSB_DEF 4
`define IDX_W_DEF 8
`define THREAD_W_DEF 16
`define CACHE_SIZE_DEF 32'h00000000
`endif

// *** core_vendor_pkg.sv ***
package core_vendor_pkg;
   typedef struct packed {
      logic valid;
      logic write;
      logic [2:0] opc2;
      logic [3:0] sel;
      logic [31:0] wdata;
   } cp_req_t;
   typedef struct packed {
      logic valid;
      logic [31:0] rdata;
   } cp_rsp_t;
   typedef enum logic [6:0] {
      TGT_NONE = 7'h01,
      TGT_CFG = 7'h02,
      TGT_HIGH = 7'h04,
      TGT_LOW = 7'h08,
      TGT_THREAD = 7'h10,
      TGT_STATUS = 7'h20,
      TGT_WFI = 7'h40
   } target_t;
endpackage

// *** sync2.sv ***
`timescale 1ns/1ps
`default_nettype none
module sync2 (
   input wire logic clk,
   input wire logic rst,
   input wire logic din,
   output logic dout
);
   logic meta_r;
   // Under reset both stages load the pin, so a strap level is ready at the output after the first reset edge
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_r <= din;
         dout <= din;
      end else begin
         meta_r <= din;
         dout <= meta_r;
      end
   end
endmodule
`default_nettype wire

// *** dirty_index_tracker.sv ***
`timescale 1ns/1ps
`default_nettype none
module dirty_index_tracker #(
   parameter int IDX_W = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic dirtyEvt,
   input wire logic [IDX_W-1:0] dirtyIdx,
   input wire logic clearEvt,
   input wire logic wrHigh,
   input wire logic wrLow,
   input wire logic [IDX_W-1:0] wrValue,
   output logic [IDX_W-1:0] highIdx,
   output logic [IDX_W-1:0] lowIdx,
   output logic anyDirty
);
   logic [IDX_W-1:0] highBase;
   logic [IDX_W-1:0] lowBase;
   always_comb begin
      highBase = highIdx;
      lowBase = lowIdx;
      if (clearEvt) begin
         highBase = '0;
         lowBase = '1;
      end else begin
         if (wrHigh) begin
            highBase = wrValue;
         end
         if (wrLow) begin
            lowBase = wrValue;
         end
      end
   end
   // A line dirtied in the clearing cycle still counts
   always_ff @(posedge clk) begin
      if (rst) begin
         highIdx <= '0;
         lowIdx <= '1;
         anyDirty <= 1'b0;
      end else begin
         highIdx <= (dirtyEvt && (clearEvt || dirtyIdx > highBase)) ? dirtyIdx : highBase;
         lowIdx <= (dirtyEvt && (clearEvt || dirtyIdx < lowBase)) ? dirtyIdx : lowBase;
         anyDirty <= dirtyEvt || (anyDirty && !clearEvt);
      end
   end
endmodule
`default_nettype wire

// *** core_vendor_control_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "core_vendor_regs.svh"
module core_vendor_control_regs #(
   parameter int IDX_LSB = `IDX_LSB_DEF,
   parameter int IDX_W = `IDX_W_DEF,
   parameter int THREAD_W = `THREAD_W_DEF,
   parameter logic [31:0] CACHE_SIZE = `CACHE_SIZE_DEF
) (
   input wire logic clk,
   input wire logic rst,
   input wire core_vendor_pkg::cp_req_t cpReq,
   output core_vendor_pkg::cp_rsp_t cpRsp,
   input wire logic os_select_input,
   input wire logic legacy_mode_force_input,
   output logic legacyMode,
   output logic pidEnable,
   output logic icacheStreamEn,
   input wire logic cleanEntryReq,
   input wire logic cleanSetBit,
   output logic [1:0] cleanSetMask,
   input wire logic lineLoadReq,
   input wire logic copyBackPending,
   input wire logic mem16Bit,
   output logic lineLoadGo,
   output logic copyBackError,
   input wire logic swapActive,
   input wire logic swapCacheable,
   input wire logic noncacheable_buffered,
   output logic busLock,
   output logic swapUnbuffered,
   input wire logic lineDirtyEvt,
   input wire logic [IDX_W-1:0] lineDirtyIdx,
   input wire logic dcacheFlush,
   input wire logic dcacheCleanDone,
   input wire logic extAbortEvt,
   output logic wfiPulse
);
   // Opcode and select to one target; status is read-only, the wait code write-only
   function automatic core_vendor_pkg::target_t decodeTarget(
      input logic [2:0] opc2,
      input logic [3:0] sel,
      input logic isWrite
   );
      core_vendor_pkg::target_t t;
      t = core_vendor_pkg::TGT_NONE;
      if (opc2 == `OPC_MAIN) begin
         case (sel)
            `SEL_CFG: begin
               t = core_vendor_pkg::TGT_CFG;
            end
            `SEL_HIGH: begin
               t = core_vendor_pkg::TGT_HIGH;
            end
            `SEL_LOW: begin
               t = core_vendor_pkg::TGT_LOW;
            end
            `SEL_THREAD: begin
               t = core_vendor_pkg::TGT_THREAD;
            end
            `SEL_STATUS: begin
               t = isWrite ? core_vendor_pkg::TGT_NONE : core_vendor_pkg::TGT_STATUS;
            end
            default: begin
               t = core_vendor_pkg::TGT_NONE;
            end
         endcase
      end else if (opc2 == `OPC_WFI && sel == `SEL_STATUS && isWrite) begin
         t = core_vendor_pkg::TGT_WFI;
      end
      return t;
   endfunction

   // Index field placed in a 32-bit word, other bits zero
   function automatic logic [31:0] placeIdx(input logic [IDX_W-1:0] idx);
      logic [31:0] w;
      w = 32'h00000000;
      w[IDX_LSB +: IDX_W] = idx;
      return w;
   endfunction

   core_vendor_pkg::target_t tgt;
   logic wrEn;
   logic rdEn;
   logic sizeRead;
   logic osSync;
   logic forceSync;
   logic [31:0] cfg_r;
   logic [31:0] cfg_nxt;
   logic [THREAD_W-1:0] thread_r;
   logic abort_r;
   logic statusRead;
   logic copyBackError_r;
   logic [IDX_W-1:0] highIdx;
   logic [IDX_W-1:0] lowIdx;
   logic anyDirty;
   logic [31:0] rdata_nxt;
   logic cfgWrite;
   logic threadWrite;
   logic highWrite;
   logic lowWrite;
   logic wfiWrite;
   logic idxClear;
   logic [31:0] cfgView;
   logic [31:0] statusWord;

   // Both pins are asynchronous to the core clock
   sync2 uOsSync (
      .clk(clk),
      .rst(rst),
      .din(os_select_input),
      .dout(osSync)
   );

   sync2 uForceSync (
      .clk(clk),
      .rst(rst),
      .din(legacy_mode_force_input),
      .dout(forceSync)
   );

   assign tgt = decodeTarget(cpReq.opc2, cpReq.sel, cpReq.write);
   assign wrEn = cpReq.valid && cpReq.write;
   assign rdEn = cpReq.valid && !cpReq.write;
   // Cache size is hard-wired: reads only, writes fall through as no-ops
   assign sizeRead = rdEn && cpReq.opc2 == `OPC_MAIN && cpReq.sel == `SEL_SIZE;
   assign statusRead = rdEn && tgt == core_vendor_pkg::TGT_STATUS;
   assign cfgWrite = wrEn && tgt == core_vendor_pkg::TGT_CFG;
   assign threadWrite = wrEn && tgt == core_vendor_pkg::TGT_THREAD;
   assign highWrite = wrEn && tgt == core_vendor_pkg::TGT_HIGH;
   assign lowWrite = wrEn && tgt == core_vendor_pkg::TGT_LOW;
   assign wfiWrite = wrEn && tgt == core_vendor_pkg::TGT_WFI;
   // A whole flush and the end of a full clean reset the dirty window alike
   assign idxClear = dcacheFlush || dcacheCleanDone;

   // Configuration: only the defined bits are stored, bit 6 and bits 4:3 read zero
   always_comb begin
      cfg_nxt = cfg_r;
      if (cfgWrite) begin
         cfg_nxt = cpReq.wdata & `CFG_WR_MASK;
      end
   end

   // The OS bit follows the synchronised pin for as long as reset is held
   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_r <= `CFG_RESET;
         cfg_r[`CFG_OS_BIT] <= osSync;
      end else begin
         cfg_r <= cfg_nxt;
      end
   end

   // Only the low field of the thread word is stored; upper bits read zero
   always_ff @(posedge clk) begin
      if (rst) begin
         thread_r <= '0;
      end else if (threadWrite) begin
         thread_r <= cpReq.wdata[THREAD_W-1:0];
      end
   end

   // Abort flag: a new abort wins over the clearing read
   always_ff @(posedge clk) begin
      if (rst) begin
         abort_r <= 1'b0;
      end else begin
         abort_r <= extAbortEvt || (abort_r && !statusRead);
      end
   end

   // Dirty window of the data cache
   dirty_index_tracker #(
      .IDX_W(IDX_W)
   ) uTracker (
      .clk(clk),
      .rst(rst),
      .dirtyEvt(lineDirtyEvt),
      .dirtyIdx(lineDirtyIdx),
      .clearEvt(idxClear),
      .wrHigh(highWrite),
      .wrLow(lowWrite),
      .wrValue(cpReq.wdata[IDX_LSB +: IDX_W]),
      .highIdx(highIdx),
      .lowIdx(lowIdx),
      .anyDirty(anyDirty)
   );

   // Mode outputs
   assign legacyMode = cfg_r[`CFG_OS_BIT] || forceSync;
   assign pidEnable = !legacyMode;
   assign icacheStreamEn = !cfg_r[`CFG_STREAM_BIT];

   // Single-entry clean: bit 1 of the mask is set 1, bit 0 is set 0
   always_comb begin
      cleanSetMask = 2'h0;
      if (cleanEntryReq) begin
         if (cfg_r[`CFG_CLEAN_BIT]) begin
            cleanSetMask = cleanSetBit ? 2'h2 : 2'h1;
         end else begin
            cleanSetMask = 2'h3;
         end
      end
   end

   // Line load sequencing against copy-back
   always_comb begin
      lineLoadGo = 1'b0;
      if (lineLoadReq) begin
         if (!copyBackPending) begin
            lineLoadGo = 1'b1;
         end else if (cfg_r[`CFG_TRANSP_BIT] && mem16Bit) begin
            lineLoadGo = 1'b1;
         end else begin
            lineLoadGo = 1'b0;
         end
      end
   end

   // Transparent mode on a 32-bit memory is a misconfiguration, flagged per copy-back
   always_ff @(posedge clk) begin
      if (rst) begin
         copyBackError_r <= 1'b0;
      end else begin
         copyBackError_r <= copyBackPending && cfg_r[`CFG_TRANSP_BIT] && !mem16Bit;
      end
   end
   assign copyBackError = copyBackError_r;

   // Swap locking
   always_comb begin
      busLock = 1'b0;
      swapUnbuffered = 1'b0;
      if (swapActive && cfg_r[`CFG_LOCK_BIT] && !swapCacheable) begin
         busLock = 1'b1;
         swapUnbuffered = noncacheable_buffered;
      end else begin
         busLock = 1'b0;
         swapUnbuffered = 1'b0;
      end
   end

   // Bit 5 reads back the effective mode, stored or forced
   always_comb begin
      cfgView = cfg_r;
      cfgView[`CFG_OS_BIT] = legacyMode;
   end

   always_comb begin
      statusWord = 32'h00000000;
      statusWord[`STAT_DIRTY_BIT] = anyDirty;
      statusWord[`STAT_ABORT_BIT] = abort_r;
   end

   // Read data mux
   always_comb begin
      rdata_nxt = 32'h00000000;
      if (sizeRead) begin
         rdata_nxt = CACHE_SIZE;
      end else begin
         case (tgt)
            core_vendor_pkg::TGT_CFG: begin
               rdata_nxt = cfgView;
            end
            core_vendor_pkg::TGT_HIGH: begin
               rdata_nxt = placeIdx(highIdx);
            end
            core_vendor_pkg::TGT_LOW: begin
               rdata_nxt = placeIdx(lowIdx);
            end
            core_vendor_pkg::TGT_THREAD: begin
               rdata_nxt[THREAD_W-1:0] = thread_r;
            end
            core_vendor_pkg::TGT_STATUS: begin
               rdata_nxt = statusWord;
            end
            default: begin
               rdata_nxt = 32'h00000000;
            end
         endcase
      end
   end

   // Every read is answered one cycle later; unmapped reads return zero
   always_ff @(posedge clk) begin
      if (rst) begin
         cpRsp <= '0;
      end else begin
         cpRsp.valid <= rdEn;
         cpRsp.rdata <= rdEn ? rdata_nxt : 32'h00000000;
      end
   end

   // Operand of the legacy wait request is discarded
   always_ff @(posedge clk) begin
      if (rst) begin
         wfiPulse <= 1'b0;
      end else begin
         wfiPulse <= wfiWrite;
      end
   end
endmodule
`default_nettype wire

// *** core_vendor_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module core_vendor_chk (
   input wire logic clk,
   input wire logic rst,
   input wire core_vendor_pkg::cp_req_t cpReq,
   input wire core_vendor_pkg::cp_rsp_t cpRsp,
   input wire logic wfiPulse,
   input wire logic icacheStreamEn,
   input wire logic legacyMode,
   input wire logic pidEnable,
   input wire logic busLock,
   input wire logic swapActive,
   input wire logic swapCacheable,
   input wire logic cleanEntryReq,
   input wire logic [1:0] cleanSetMask,
   input wire logic lineLoadReq,
   input wire logic copyBackPending,
   input wire logic lineLoadGo
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_rd;
      cpReq.valid && !cpReq.write;
   endsequence
   sequence s_wfi;
      cpReq.valid && cpReq.write && cpReq.opc2 == 3'h2 && cpReq.sel == 4'h8;
   endsequence
   sequence s_cfg;
      cpReq.valid && cpReq.write && cpReq.opc2 == 3'h0 && cpReq.sel == 4'h1;
   endsequence
   property p_rsp; s_rd |=> cpRsp.valid; endproperty
   property p_idle; !(cpReq.valid && !cpReq.write) |=> cpRsp == '0; endproperty
   property p_wfi; s_wfi |=> wfiPulse; endproperty
   property p_stream; s_cfg |=> icacheStreamEn == !$past(cpReq.wdata[7]); endproperty
   property p_pid; pidEnable != legacyMode; endproperty
   property p_lock; busLock |-> swapActive && !swapCacheable; endproperty
   property p_clean; !cleanEntryReq |-> cleanSetMask == 2'h0; endproperty
   property p_load; lineLoadReq && !copyBackPending |-> lineLoadGo; endproperty
   property p_os; s_cfg ##0 cpReq.wdata[5] |=> legacyMode; endproperty
   a_rsp: assert property (p_rsp) else $error("read not answered");
   a_idle: assert property (p_idle) else $error("answer without read");
   a_wfi: assert property (p_wfi) else $error("wait pulse missing");
   a_stream: assert property (p_stream) else $error("stream enable wrong");
   a_pid: assert property (p_pid) else $error("pid enable wrong");
   a_lock: assert property (p_lock) else $error("bus lock wrong");
   a_clean: assert property (p_clean) else $error("clean mask wrong");
   a_load: assert property (p_load) else $error("line load held");
   a_os: assert property (p_os) else $error("legacy mode not taken from config");
endmodule
`default_nettype wire

// *** cp_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module cp_core_model (
   input wire logic clk,
   output core_vendor_pkg::cp_req_t cpReq,
   input wire core_vendor_pkg::cp_rsp_t cpRsp
);
   initial cpReq = '0;
   // One transfer per call, taken at the rising edge between two falling edges
   task automatic issue(input logic wr, input logic [2:0] o, input logic [3:0] s,
         input logic [31:0] d, output core_vendor_pkg::cp_rsp_t rsp);
      @(negedge clk);
      if (wr && o == 3'h0 && s == 4'h1) d[6] = 1'b0;
      cpReq = {1'b1, wr, o, s, d};
      @(negedge clk);
      rsp = cpRsp;
      cpReq.valid = 1'b0;
      cpReq.wdata = ~cpReq.wdata;
   endtask
endmodule
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam logic [31:0] SZ = 32'h1234ABCD; // Arbitrary value
   logic clk = 1'b0;
   logic rst = 1'b1;
   core_vendor_pkg::cp_req_t cpReq;
   core_vendor_pkg::cp_rsp_t cpRsp, r;
   logic legacyMode, pidEnable, icacheStreamEn, lineLoadGo, copyBackError;
   logic busLock, swapUnbuffered, wfiPulse, lk;
   logic [1:0] cleanSetMask;
   logic os_select_input = 0, legacy_mode_force_input = 0, noncacheable_buffered = 0;
   logic cleanEntryReq = 0, cleanSetBit = 0, lineLoadReq = 0, copyBackPending = 0;
   logic mem16Bit = 0, swapActive = 0, swapCacheable = 0, lineDirtyEvt = 0;
   logic dcacheFlush = 0, dcacheCleanDone = 0, extAbortEvt = 0;
   logic [7:0] lineDirtyIdx = 8'h00, d;
   logic [31:0] w;
   int miscompares = 0, num_checks = 0, hiM, loM;
   always #2.5 clk = ~clk;
   cp_core_model u_core (.clk, .cpReq, .cpRsp);
   core_vendor_control_regs #(.CACHE_SIZE(SZ)) u_dut (.clk, .rst, .cpReq, .cpRsp,
      .os_select_input, .legacy_mode_force_input, .legacyMode, .pidEnable, .icacheStreamEn,
      .cleanEntryReq, .cleanSetBit, .cleanSetMask, .lineLoadReq, .copyBackPending, .mem16Bit,
      .lineLoadGo, .copyBackError, .swapActive, .swapCacheable, .noncacheable_buffered,
      .busLock, .swapUnbuffered, .lineDirtyEvt, .lineDirtyIdx, .dcacheFlush,
      .dcacheCleanDone, .extAbortEvt, .wfiPulse);
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rdc(input logic [2:0] o, input logic [3:0] s, input logic [31:0] e);
      u_core.issue(1'b0, o, s, 32'h0, r);
      chk($sformatf("read %0d/%0d", o, s), r.valid === 1'b1 ? r.rdata : ~e, e);
   endtask
   task automatic wr(input logic [2:0] o, input logic [3:0] s, input logic [31:0] v);
      u_core.issue(1'b1, o, s, v, r);
   endtask
   // Kind 0 dirty line, 1 flush, 2 clean done, 3 external abort
   task automatic ev(input int k, input logic [7:0] v);
      @(negedge clk);
      {lineDirtyEvt, dcacheFlush, dcacheCleanDone, extAbortEvt} = 4'h8 >> k;
      lineDirtyIdx = v;
      @(negedge clk);
      {lineDirtyEvt, dcacheFlush, dcacheCleanDone, extAbortEvt} = 4'h0;
      lineDirtyIdx = ~v;
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      #100000;
      miscompares++;
      end_of_test();
   end
   initial begin
      void'($urandom(9));
      repeat (2) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      rdc(0, 1, 32'h1);
      rdc(0, 2, 32'h0);
      rdc(0, 3, 32'hFF0);
      rdc(0, 4, 32'h0);
      rdc(0, 0, SZ);
      rdc(0, 8, 32'h0);
      for (int i = 0; i < 24; i++) begin
         w = $urandom;
         wr(0, 1, w);
         {cleanEntryReq, cleanSetBit, lineLoadReq, copyBackPending, mem16Bit, swapActive,
            swapCacheable, noncacheable_buffered} = 8'($urandom);
         @(negedge clk);
         lk = swapActive & w[0] & !swapCacheable;
         chk("pins", {23'h0, legacyMode, pidEnable, icacheStreamEn, cleanSetMask, lineLoadGo,
            copyBackError, busLock, swapUnbuffered}, {23'h0, w[5], !w[5], !w[7],
            !cleanEntryReq ? 2'h0 : !w[2] ? 2'h3 : {cleanSetBit, !cleanSetBit},
            lineLoadReq & (!copyBackPending | (w[1] & mem16Bit)),
            copyBackPending & w[1] & !mem16Bit, lk, lk & noncacheable_buffered});
         rdc(0, 1, w & 32'hA7);
         wr(0, 4, ~w);
         rdc(0, 4, {16'h0, ~w[15:0]});
      end
      wr(0, 1, 32'h0);
      legacy_mode_force_input = 1'b1;
      repeat (3) @(negedge clk);
      chk("force", {31'h0, legacyMode}, 32'h1);
      rdc(0, 1, 32'h20);
      legacy_mode_force_input = 1'b0;
      hiM = 0;
      loM = 255;
      for (int k = 0; k < 6; k++) begin
         d = 8'($urandom);
         ev(0, d);
         hiM = d > hiM ? d : hiM;
         loM = d < loM ? d : loM;
      end
      rdc(0, 2, hiM << 4);
      rdc(0, 3, loM << 4);
      rdc(0, 8, 32'h80000000);
      for (int k = 1; k < 3; k++) begin
         ev(0, 8'($urandom));
         ev(k, 8'h0);
         rdc(0, 2, 32'h0);
         rdc(0, 3, 32'hFF0);
      end
      wr(0, 2, 32'h00000A50);
      wr(0, 3, 32'h00000350);
      rdc(0, 2, 32'hA50);
      rdc(0, 3, 32'h350);
      ev(3, 8'h0);
      rdc(0, 8, 32'h10);
      rdc(0, 8, 32'h0);
      wr(2, 8, $urandom);
      chk("wait", {31'h0, wfiPulse}, 32'h1);
      @(negedge clk);
      chk("wait end", {31'h0, wfiPulse}, 32'h0);
      wr(0, 8, 32'hFFFFFFFF);
      wr(0, 0, 32'hFFFFFFFF);
      wr(1, 1, 32'hFFFFFFFF);
      rdc(0, 8, 32'h0);
      rdc(0, 0, SZ);
      rdc(2, 8, 32'h0);
      rdc(0, 1, 32'h0);
      // Second reset with the OS strap high
      os_select_input = 1'b1;
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      rdc(0, 1, 32'h21);
      rdc(0, 2, 32'h0);
      rdc(0, 3, 32'hFF0);
      end_of_test();
   end
endmodule
bind core_vendor_control_regs core_vendor_chk u_chk (.clk, .rst, .cpReq, .cpRsp, .wfiPulse,
   .icacheStreamEn, .legacyMode, .pidEnable, .busLock, .swapActive, .swapCacheable,
   .cleanEntryReq, .cleanSetMask, .lineLoadReq, .copyBackPending, .lineLoadGo);
`default_nettype wire
